// ---- inc/pac_pkg.sv ----
// Purpose: Shared constants and carriers for the translation-side PCIe configuration register bank
// Assumes: 32-bit register port, each 64-bit register split into a low and a high word
// Notes: Byte addresses of the register words; interrupt words sit after the bank
package pac_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 32;
   // Register word byte addresses
   localparam logic [16:0] STAT_LO_ADDR = 17'h1_9840;
   localparam logic [16:0] STAT_HI_ADDR = 17'h1_9844;
   localparam logic [16:0] CTRL_LO_ADDR = 17'h1_9860;
   localparam logic [16:0] CTRL_HI_ADDR = 17'h1_9864;
   localparam logic [16:0] EXT_LO_ADDR = 17'h1_9870;
   localparam logic [16:0] EXT_HI_ADDR = 17'h1_9874;
   localparam logic [16:0] IRQ_STAT_ADDR = 17'h1_9880;
   localparam logic [16:0] IRQ_MASK_ADDR = 17'h1_9884;
   // Values after reset
   localparam logic [63:0] STAT_RST = 64'h0000_0000_0000_0100;
   localparam logic [63:0] CTRL_RST = 64'h0000_0000_FF00_0000;
   localparam logic [63:0] EXT_RST = 64'h03FF_0000_0000_0000;
   localparam logic [1:0] IRQ_RST = 2'h0;
   // Interrupt event bit positions
   localparam int IRQ_RFAIL_BIT = 0;
   localparam int IRQ_UGI_BIT = 1;
   // Function-ID select encodings
   typedef enum logic [1:0] {
      PAC_FSEL_BDF = 2'h0,
      PAC_FSEL_PARTIAL = 2'h1,
      PAC_FSEL_FULL = 2'h2,
      PAC_FSEL_RSVD = 2'h3
   } pac_fsel_t;
   // Page-request status layout
   typedef struct packed {
      logic [47:0] rsv_hi;
      logic prg_pasid_required;
      logic [5:0] rsv_mid;
      logic prg_stop_flag;
      logic [5:0] rsv_lo;
      logic unexpected_group_index_flag;
      logic response_failure_flag;
   } pac_stat_t;
   // Link identity control layout
   typedef struct packed {
      logic [15:0] root_complex_identity;
      logic [3:0] rsv;
      logic ecrc_enable;
      logic [10:0] max_payload_size;
      logic [7:0] tag8_upper_limit;
      logic [7:0] tag8_lower_limit;
      logic [15:0] endpoint_identity;
   } pac_ctrl_t;
   // Extended identity control layout
   typedef struct packed {
      logic [1:0] function_id_select;
      logic tag10_enable;
      logic poison_request_enable;
      logic [1:0] rsv_a;
      logic [9:0] tag10_upper_limit;
      logic [5:0] rsv_b;
      logic [9:0] tag10_lower_limit;
      logic [16:0] rsv_c;
      logic [1:0] endpoint_component_id;
      logic [12:0] endpoint_function_id;
   } pac_ext_t;
   // Identities placed in generated packets
   typedef struct packed {
      logic [15:0] completer_id;
      logic [15:0] requester_id;
      logic [15:0] device_id;
   } pac_ids_t;
   // Active tag window
   typedef struct packed {
      logic [9:0] upper;
      logic [9:0] lower;
   } pac_tags_t;
endpackage : pac_pkg

// ---- src/pac_regs.sv ----
// Purpose: Page-request status and PCIe identity control registers with derived link settings
// Assumes: All event and status inputs come from logic on clk; plain register port
// Notes: 64-bit registers are reached as two 32-bit words, low word at the lower address
//
// Contract
// - PASID-required flag bit 15 read-only, reset 0, zero outside PASID context.
// - Status: read-only stop bit 8 reset 1; R/W flags bits 1 and 0 reset 0.
// - Root identity 63:48, endpoint identity 15:0, max payload 42:32, all R/W, reset 0.
// - Eight-bit tag limits: upper 31:24 reset FF, lower 23:16 reset 0.
// - ECRC enable bit 43 R/W, reset 0, turns on end-to-end CRC.
// - Select 01 partial function ID on completer/requester; 10 everywhere; 11 reserved.
// - Select 00 uses endpoint identity for completer, requester and device IDs.
// - Bit 61 chooses 8-bit overloaded tags or 10-bit tags on both interfaces.
// - In 10-bit mode the 10-bit limits apply and 8-bit limits are ignored.
// - Ten-bit upper limit 57:48 reset 3FF, lower limit 41:32 reset 0.
// - Poison bit 60 poisons on uncorrectable payload error, only in 10-bit mode; code also requires aer_enable.
// - Thirteen-bit function ID 12:0 R/W, used only when function ID selected.
//
// Implementation choices: strobed register access and the placing of the registers.
module pac_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [pac_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pac_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pac_pkg::DATA_W-1:0] reg_rdata,
   input wire logic pasid_ctx_en,
   input wire logic prg_pasid_required_in,
   input wire logic prg_stop_in,
   input wire logic response_failure_evt,
   input wire logic unexpected_group_index_evt,
   input wire logic aer_enable,
   output pac_pkg::pac_ids_t ids,
   output pac_pkg::pac_tags_t tag_window,
   output logic tag10_mode,
   output logic ecrc_on,
   output logic [10:0] max_payload,
   output logic [15:0] root_identity,
   output logic poison_on,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   pac_pkg::pac_stat_t stat_r, stat_nxt;
   pac_pkg::pac_ctrl_t ctrl_r, ctrl_nxt;
   pac_pkg::pac_ext_t ext_r, ext_nxt;
   logic [1:0] irq_stat_r, irq_stat_nxt;
   logic [1:0] irq_mask_r, irq_mask_nxt;
   logic [1:0] evt;
   logic wr_stat_lo, wr_ctrl_lo, wr_ctrl_hi, wr_ext_lo, wr_ext_hi, wr_istat, wr_imask;

   // Write decode
   assign wr_stat_lo = reg_wr && (reg_addr == pac_pkg::STAT_LO_ADDR);
   assign wr_ctrl_lo = reg_wr && (reg_addr == pac_pkg::CTRL_LO_ADDR);
   assign wr_ctrl_hi = reg_wr && (reg_addr == pac_pkg::CTRL_HI_ADDR);
   assign wr_ext_lo = reg_wr && (reg_addr == pac_pkg::EXT_LO_ADDR);
   assign wr_ext_hi = reg_wr && (reg_addr == pac_pkg::EXT_HI_ADDR);
   assign wr_istat = reg_wr && (reg_addr == pac_pkg::IRQ_STAT_ADDR);
   assign wr_imask = reg_wr && (reg_addr == pac_pkg::IRQ_MASK_ADDR);
   assign evt = {unexpected_group_index_evt, response_failure_evt};

   ////////////////////////////////////////////////////////////////////////////
   // Next register contents
   always_comb begin
      stat_nxt = stat_r;
      ctrl_nxt = ctrl_r;
      ext_nxt = ext_r;
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      // Status flags: write stores, hardware event sets and wins
      if (wr_stat_lo) begin
         stat_nxt.response_failure_flag = reg_wdata[0];
         stat_nxt.unexpected_group_index_flag = reg_wdata[1];
      end
      if (response_failure_evt) begin
         stat_nxt.response_failure_flag = 1'b1;
      end
      if (unexpected_group_index_evt) begin
         stat_nxt.unexpected_group_index_flag = 1'b1;
      end
      stat_nxt.prg_stop_flag = prg_stop_in;
      stat_nxt.prg_pasid_required = pasid_ctx_en & prg_pasid_required_in;
      // Control words
      if (wr_ctrl_lo) begin
         ctrl_nxt[31:0] = reg_wdata;
      end
      if (wr_ctrl_hi) begin
         ctrl_nxt[63:32] = reg_wdata;
      end
      if (wr_ext_lo) begin
         ext_nxt[31:0] = reg_wdata;
      end
      if (wr_ext_hi) begin
         ext_nxt[63:32] = reg_wdata;
      end
      // Reserved fields hold zero
      stat_nxt.rsv_hi = '0;
      stat_nxt.rsv_mid = '0;
      stat_nxt.rsv_lo = '0;
      ctrl_nxt.rsv = '0;
      ext_nxt.rsv_a = '0;
      ext_nxt.rsv_b = '0;
      ext_nxt.rsv_c = '0;
      // Interrupt status: write one clears, a new event wins
      if (wr_istat) begin
         irq_stat_nxt = irq_stat_r & ~reg_wdata[1:0];
      end
      irq_stat_nxt = irq_stat_nxt | evt;
      if (wr_imask) begin
         irq_mask_nxt = reg_wdata[1:0];
      end
   end

   // Register storage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_r <= pac_pkg::pac_stat_t'(pac_pkg::STAT_RST);
         ctrl_r <= pac_pkg::pac_ctrl_t'(pac_pkg::CTRL_RST);
         ext_r <= pac_pkg::pac_ext_t'(pac_pkg::EXT_RST);
         irq_stat_r <= pac_pkg::IRQ_RST;
         irq_mask_r <= pac_pkg::IRQ_RST;
      end else begin
         stat_r <= stat_nxt;
         ctrl_r <= ctrl_nxt;
         ext_r <= ext_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] rdata_r, rdata_nxt;

   // Read mux, unmapped words read zero
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            pac_pkg::STAT_LO_ADDR: rdata_nxt = stat_r[31:0];
            pac_pkg::STAT_HI_ADDR: rdata_nxt = stat_r[63:32];
            pac_pkg::CTRL_LO_ADDR: rdata_nxt = ctrl_r[31:0];
            pac_pkg::CTRL_HI_ADDR: rdata_nxt = ctrl_r[63:32];
            pac_pkg::EXT_LO_ADDR: rdata_nxt = ext_r[31:0];
            pac_pkg::EXT_HI_ADDR: rdata_nxt = ext_r[63:32];
            pac_pkg::IRQ_STAT_ADDR: rdata_nxt = {30'h0, irq_stat_r};
            pac_pkg::IRQ_MASK_ADDR: rdata_nxt = {30'h0, irq_mask_r};
            default: rdata_nxt = '0;
         endcase
      end
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   pac_pkg::pac_ids_t ids_r, ids_nxt;
   pac_pkg::pac_tags_t tags_r, tags_nxt;
   logic tag10_r, ecrc_r, poison_r, irq_r;
   logic [10:0] mps_r;
   logic [15:0] root_r;
   logic [15:0] fid16;

   // Function identity as a 16-bit ID field
   assign fid16 = {1'b0, ext_r.endpoint_component_id, ext_r.endpoint_function_id};

   // Derived link settings
   always_comb begin
      ids_nxt.completer_id = ctrl_r.endpoint_identity;
      ids_nxt.requester_id = ctrl_r.endpoint_identity;
      ids_nxt.device_id = ctrl_r.endpoint_identity;
      case (pac_pkg::pac_fsel_t'(ext_r.function_id_select))
         pac_pkg::PAC_FSEL_PARTIAL: begin
            ids_nxt.completer_id = fid16;
            ids_nxt.requester_id = fid16;
         end
         pac_pkg::PAC_FSEL_FULL: begin
            ids_nxt.completer_id = fid16;
            ids_nxt.requester_id = fid16;
            ids_nxt.device_id = fid16;
         end
         default: begin
            ids_nxt.device_id = ctrl_r.endpoint_identity;
         end
      endcase
      if (ext_r.tag10_enable) begin
         tags_nxt.upper = ext_r.tag10_upper_limit;
         tags_nxt.lower = ext_r.tag10_lower_limit;
      end else begin
         tags_nxt.upper = {2'h0, ctrl_r.tag8_upper_limit};
         tags_nxt.lower = {2'h0, ctrl_r.tag8_lower_limit};
      end
   end

   // Output registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ids_r <= '0;
         tags_r <= '0;
         tag10_r <= 1'b0;
         ecrc_r <= 1'b0;
         mps_r <= '0;
         root_r <= '0;
         poison_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         ids_r <= ids_nxt;
         tags_r <= tags_nxt;
         tag10_r <= ext_r.tag10_enable;
         ecrc_r <= ctrl_r.ecrc_enable;
         mps_r <= ctrl_r.max_payload_size;
         root_r <= ctrl_r.root_complex_identity;
         poison_r <= ext_r.poison_request_enable & ext_r.tag10_enable & aer_enable;
         irq_r <= |(irq_stat_nxt & irq_mask_nxt);
      end
   end

   assign ids = ids_r;
   assign tag_window = tags_r;
   assign tag10_mode = tag10_r;
   assign ecrc_on = ecrc_r;
   assign max_payload = mps_r;
   assign root_identity = root_r;
   assign poison_on = poison_r;
   assign irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_PASID_OUTSIDE_CTX: assert property (!pasid_ctx_en |=> !stat_r.prg_pasid_required)
      else $error("PASID-required flag set outside PASID context");
   AST_STOP_TRACKS: assert property (prg_stop_in |=> stat_r.prg_stop_flag)
      else $error("Stop flag does not follow its source");
   AST_FAIL_SET_WINS: assert property (response_failure_evt |=>
      stat_r.response_failure_flag && irq_stat_r[pac_pkg::IRQ_RFAIL_BIT])
      else $error("Response failure event lost");
   AST_STOP_RO: assert property (wr_stat_lo |=> stat_r.prg_stop_flag == $past(prg_stop_in))
      else $error("Write reached the read-only stop flag");
   AST_FAIL_RACE: assert property (wr_stat_lo && response_failure_evt |=> stat_r.response_failure_flag)
      else $error("Status write beat a response failure event");

   // Link control: identity, payload size and read port behaviour
   AST_ROOT_WRITE: assert property (wr_ctrl_hi |-> ##2 root_identity == $past(reg_wdata[31:16], 2))
      else $error("Root identity write not seen at output");
   AST_MPS_WRITE: assert property (wr_ctrl_hi |-> ##2 max_payload == $past(reg_wdata[10:0], 2))
      else $error("Max payload write not seen at output");
   AST_TAG8_WINDOW: assert property (!ext_r.tag10_enable |=>
      tag_window.upper == {2'h0, $past(ctrl_r.tag8_upper_limit)})
      else $error("Eight-bit upper tag limit not applied");
   AST_ECRC: assert property (ctrl_r.ecrc_enable |=> ecrc_on)
      else $error("ECRC enable not driven");
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("Read data not zero outside a read cycle");
   AST_RSVD_ZERO: assert property (reg_rd && reg_addr == pac_pkg::STAT_LO_ADDR |=>
      reg_rdata[7:2] == 6'h0 && reg_rdata[14:9] == 6'h0 && reg_rdata[31:16] == 16'h0)
      else $error("Reserved status bits read nonzero");

   // Extended control: tag mode, limits, identities and poison
   AST_TAG10_MODE: assert property (tag10_mode == $past(ext_r.tag10_enable))
      else $error("Tag mode output does not follow its control bit");
   AST_TAG10_WINDOW: assert property (ext_r.tag10_enable |=>
      tag_window.lower == $past(ext_r.tag10_lower_limit) && tag10_mode)
      else $error("Ten-bit tag limits not applied");
   AST_TAG10_UPPER: assert property (ext_r.tag10_enable |=>
      tag_window.upper == $past(ext_r.tag10_upper_limit))
      else $error("Ten-bit upper tag limit not applied");
   AST_PARTIAL_IDS: assert property (ext_r.function_id_select == 2'h1 |=>
      ids.device_id == $past(ctrl_r.endpoint_identity) && ids.requester_id == $past(fid16))
      else $error("Partial function ID placement wrong");
   AST_FULL_IDS: assert property (ext_r.function_id_select == 2'h2 |=>
      ids.device_id == $past(fid16) && ids.completer_id == $past(fid16))
      else $error("Full function ID placement wrong");
   AST_BDF_IDS: assert property (ext_r.function_id_select == 2'h0 |=>
      ids.completer_id == $past(ctrl_r.endpoint_identity) && ids.device_id == $past(ctrl_r.endpoint_identity))
      else $error("Endpoint identity not used in legacy mode");
   AST_POISON_8BIT: assert property (!ext_r.tag10_enable |=> !poison_on)
      else $error("Poison active in eight-bit tag mode");
   AST_POISON_ON: assert property (ext_r.poison_request_enable && ext_r.tag10_enable && aer_enable |=>
      poison_on)
      else $error("Poison not enabled in ten-bit tag mode");
   AST_FID_STORE: assert property (wr_ext_lo |=> ext_r.endpoint_function_id == $past(reg_wdata[12:0]))
      else $error("Function ID write not stored");

   // Interrupt level follows unmasked sticky bits
   AST_IRQ_LEVEL: assert property (irq == |(irq_stat_r & irq_mask_r))
      else $error("Interrupt level does not match status and mask");

   COV_TAG10: cover property (wr_ext_hi && reg_wdata[29] ##1 ext_r.tag10_enable);
   COV_FULL_FID: cover property (ext_r.function_id_select == 2'h2 ##1 ids.device_id == fid16);
   COV_IRQ: cover property (response_failure_evt ##[1:3] irq);
   COV_CLEAR_RACE: cover property (wr_istat && reg_wdata[0] && response_failure_evt);
endmodule : pac_regs

// ---- tb/pac_regs_tb.sv ----
// Purpose: Self-checking bench for the page-request status and PCIe identity control register bank
// Assumes: Register port takes a strobe at a rising edge; read data stand only in the following cycle
// Notes: Derived outputs are sampled one edge after the register write edge
module pac_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [16:0] reg_addr = 17'h0_0000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pasid_ctx_en = 1'b0;
   logic prg_pasid_required_in = 1'b0;
   logic prg_stop_in = 1'b1;
   logic response_failure_evt = 1'b0;
   logic unexpected_group_index_evt = 1'b0;
   logic aer_enable = 1'b0;
   pac_pkg::pac_ids_t ids;
   pac_pkg::pac_tags_t tag_window;
   logic tag10_mode;
   logic ecrc_on;
   logic [10:0] max_payload;
   logic [15:0] root_identity;
   logic poison_on;
   logic irq;
   int bad_count = 0;
   int samples_checked = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and design under test
   always #12.5 clk = ~clk;

   pac_regs dut_u (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pasid_ctx_en(pasid_ctx_en),
      .prg_pasid_required_in(prg_pasid_required_in), .prg_stop_in(prg_stop_in),
      .response_failure_evt(response_failure_evt), .unexpected_group_index_evt(unexpected_group_index_evt),
      .aer_enable(aer_enable), .ids(ids), .tag_window(tag_window), .tag10_mode(tag10_mode),
      .ecrc_on(ecrc_on), .max_payload(max_payload), .root_identity(root_identity),
      .poison_on(poison_on), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Shared bus and compare tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [16:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data are judged in the single cycle after the strobe edge
   task automatic rd(input logic [16:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({32'h0000_0000, reg_rdata}, {32'h0000_0000, exp});
   endtask : rd

   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle

   task automatic pulse(input logic which);
      @(posedge clk);
      if (which) unexpected_group_index_evt <= 1'b1;
      else response_failure_evt <= 1'b1;
      @(posedge clk);
      unexpected_group_index_evt <= 1'b0;
      response_failure_evt <= 1'b0;
      #1;
   endtask : pulse

   // Event raised in the same cycle as a clearing write
   task automatic race(input logic [16:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      response_failure_evt <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      response_failure_evt <= 1'b0;
   endtask : race

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   // Values after reset, unmapped space and derived outputs
   task automatic t_reset();
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0100);
      rd(pac_pkg::STAT_HI_ADDR, 32'h0000_0000);
      rd(pac_pkg::CTRL_LO_ADDR, 32'hFF00_0000);
      rd(pac_pkg::CTRL_HI_ADDR, 32'h0000_0000);
      rd(pac_pkg::EXT_LO_ADDR, 32'h0000_0000);
      rd(pac_pkg::EXT_HI_ADDR, 32'h03FF_0000);
      rd(pac_pkg::IRQ_STAT_ADDR, 32'h0000_0000);
      wr(17'h1_9850, 32'hFFFF_FFFF);
      rd(17'h1_9850, 32'h0000_0000);
      chk({44'h0, tag_window}, {44'h0, 10'h0FF, 10'h000});
      chk({16'h0, ids}, 64'h0000_0000_0000_0000);
   endtask : t_reset

   // All-ones writes, component ID bits of the extended low word kept clear: reserved bits read zero, read-only bits keep their sources
   task automatic t_rw();
      wr(pac_pkg::CTRL_LO_ADDR, 32'hFFFF_FFFF);
      rd(pac_pkg::CTRL_LO_ADDR, 32'hFFFF_FFFF);
      wr(pac_pkg::CTRL_HI_ADDR, 32'hFFFF_FFFF);
      rd(pac_pkg::CTRL_HI_ADDR, 32'hFFFF_0FFF);
      chk({52'h0, ecrc_on, max_payload}, {52'h0, 1'b1, 11'h7FF});
      chk({48'h0, root_identity}, 64'h0000_0000_0000_FFFF);
      wr(pac_pkg::EXT_LO_ADDR, 32'hFFFF_9FFF);
      rd(pac_pkg::EXT_LO_ADDR, 32'h0000_1FFF);
      wr(pac_pkg::EXT_HI_ADDR, 32'hFFFF_FFFF);
      rd(pac_pkg::EXT_HI_ADDR, 32'hF3FF_03FF);
      wr(pac_pkg::STAT_LO_ADDR, 32'hFFFF_FFFF);
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0103);
      wr(pac_pkg::STAT_LO_ADDR, 32'h0000_0000);
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0100);
      wr(pac_pkg::CTRL_HI_ADDR, 32'h0000_0000);
      settle();
      chk({47'h0, ecrc_on, root_identity}, 64'h0000_0000_0000_0000);
   endtask : t_rw

   // Every function-ID select code, both tag modes and the poison gate
   task automatic t_ids();
      logic [15:0] ep;
      logic [15:0] fn;
      ep = 16'h1234;
      fn = 16'h0ABC;
      wr(pac_pkg::CTRL_LO_ADDR, 32'h4010_1234);
      wr(pac_pkg::EXT_LO_ADDR, 32'h0000_0ABC);
      for (int s = 0; s < 4; s++) begin
         wr(pac_pkg::EXT_HI_ADDR, {s[1:0], 30'h0300_0100});
         settle();
         case (s)
            1: chk({16'h0, ids}, {16'h0, fn, fn, ep});
            2: chk({16'h0, ids}, {16'h0, fn, fn, fn});
            default: chk({16'h0, ids}, {16'h0, ep, ep, ep});
         endcase
         chk({44'h0, tag_window}, {44'h0, 10'h040, 10'h010});
      end
      aer_enable <= 1'b1;
      wr(pac_pkg::EXT_HI_ADDR, 32'h1300_0100);
      settle();
      chk({63'h0, poison_on}, 64'h0);
      wr(pac_pkg::EXT_HI_ADDR, 32'h3300_0100);
      settle();
      chk({44'h0, tag_window}, {44'h0, 10'h300, 10'h100});
      chk({62'h0, tag10_mode, poison_on}, 64'h3);
      @(posedge clk);
      aer_enable <= 1'b0;
      settle();
      settle();
      chk({63'h0, poison_on}, 64'h0);
   endtask : t_ids

   // Events set sticky flags; mask, write-one-clear and the level interrupt
   task automatic t_events();
      wr(pac_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
      pulse(1'b0);
      chk({63'h0, irq}, 64'h1);
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0101);
      pulse(1'b1);
      rd(pac_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
      wr(pac_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
      settle();
      chk({63'h0, irq}, 64'h0);
      wr(pac_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
      settle();
      chk({63'h0, irq}, 64'h1);
      wr(pac_pkg::IRQ_STAT_ADDR, 32'h0000_0002);
      settle();
      chk({63'h0, irq}, 64'h0);
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0103);
      race(pac_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
      rd(pac_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
      race(pac_pkg::STAT_LO_ADDR, 32'h0000_0000);
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0101);
      wr(pac_pkg::STAT_LO_ADDR, 32'h0000_0000);
      prg_pasid_required_in <= 1'b1;
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_0100);
      pasid_ctx_en <= 1'b1;
      prg_stop_in <= 1'b0;
      settle();
      rd(pac_pkg::STAT_LO_ADDR, 32'h0000_8000);
   endtask : t_events

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and main sequence
   task automatic close_out();
      $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_rw();
      t_ids();
      t_events();
      close_out();
   end

   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out();
   end
endmodule : pac_regs_tb
